/* rtl/pioxb_regs.vh */
// register offsets, field positions and reset values of the port crossbar block
`ifndef PIOXB_REGS_VH
`define PIOXB_REGS_VH

// ==========================================================
// byte register offsets
`define PIOXB_ADDR_W            6
`define PIOXB_PORT0_LATCH       6'h00
`define PIOXB_PORT1_LATCH       6'h01
`define PIOXB_PORT2_LATCH       6'h02
`define PIOXB_PORT3_LATCH       6'h03
`define PIOXB_PORT0_MODE        6'h04
`define PIOXB_PORT1_MODE        6'h05
`define PIOXB_PORT2_MODE        6'h06
`define PIOXB_PORT3_MODE        6'h07
`define PIOXB_PORT1_INMODE      6'h08
`define PIOXB_XBAR_CFG3         6'h09
`define PIOXB_EDGE_FLAGS        6'h0A
`define PIOXB_EDGE_IRQ_EN       6'h0B
`define PIOXB_PERIPH_EN         6'h0C
// single-bit window: addr[5]=1, addr[4:3]=port, addr[2:0]=bit
`define PIOXB_BIT_WIN           1'b1

// ==========================================================
// field positions
`define PIOXB_XBAR_EN_BIT       6
`define PIOXB_PUD_BIT           7
`define PIOXB_EDGE6_FLAG_BIT    0
`define PIOXB_EDGE7_FLAG_BIT    1
`define PIOXB_EDGE6_POL_BIT     2
`define PIOXB_EDGE7_POL_BIT     3
`define PIOXB_PEN_SERBUS_BIT    0
`define PIOXB_PEN_SERIAL0_BIT   1
`define PIOXB_PEN_SERIAL1_BIT   2
`define PIOXB_EDGE6_PIN         30
`define PIOXB_EDGE7_PIN         31

// ==========================================================
// reset values
`define PIOXB_LATCH_RST         8'hFF
`define PIOXB_MODE_RST          8'h00
`define PIOXB_INMODE_RST        8'hFF
`define PIOXB_CFG3_RST          8'h00
`define PIOXB_EDGE_RST          8'h00
`define PIOXB_IRQ_EN_RST        8'h00
`define PIOXB_PEN_RST           8'h00

// ==========================================================
// peripheral signal slots, in crossbar priority order
`define PIOXB_SIG_SDA           3'h0
`define PIOXB_SIG_SCL           3'h1
`define PIOXB_SIG_TX0           3'h2
`define PIOXB_SIG_RX0           3'h3
`define PIOXB_SIG_TX1           3'h4
`define PIOXB_SIG_RX1           3'h5
`define PIOXB_SIG_NONE          3'h7
`define PIOXB_NUM_SIG           6

`endif

/* rtl/pioxb_sync.v */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pioxb_sync #(
    parameter WIDTH = 32
) (
    // clock and reset
    input  wire             core_clk_i,
    input  wire             rst_b_i,
    // pins in, settled levels out
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] level_o
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync2_reg;
    reg [WIDTH-1:0] sync3_reg;
    integer         i;

    // ==========================================================
    // level changes only where stages two and three agree
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_reg  <= {WIDTH{1'b1}};
            sync2_reg <= {WIDTH{1'b1}};
            sync3_reg <= {WIDTH{1'b1}};
            level_o   <= {WIDTH{1'b1}};
        end else begin
            meta_reg  <= async_i;
            sync2_reg <= meta_reg;
            sync3_reg <= sync2_reg;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    level_o[i] <= sync3_reg[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

/* rtl/pioxb_top.v */
// four-port pin logic with crossbar, output modes, pull-ups and edge interrupts
`timescale 1ns/1ps
`default_nettype none
`include "pioxb_regs.vh"

// Behaviour
// - unallocated pins are read and written through byte and bit addressable latches
// - allocated pins take output from their peripheral; latch writes do not reach them
// - ordinary reads return the sensed pin level, allocated or not
// - read-modify-write reads return latch contents instead of pin levels
// - all output drivers stay off until the crossbar enable bit is set
// - receive pins have their output driver disabled unless their serial port is in mode 0
// - push-pull drives low for 0 and high for 1
// - open-drain drives low for 0, releases for 1; open-drain after reset
// - each pin has its own mode bit, 1 push-pull, 0 open-drain
// - serial bus pins and mode-0 receive pins are always open-drain
// - port 3 pins 6 and 7 detect edges with selectable polarity
// - an active edge sets its flag and requests an interrupt if enabled
// - pull-ups on by default; global disable bit turns all off
// - pull-up is off on any pin driving low
// - port 1 pin is analog when its input mode bit is 0; reset digital
// - analog port 1 pins have digital input off and read as 0
// - analog port 1 pins lose pull-up and are skipped by the crossbar
module pioxb_top #(
    parameter NPINS = 32
) (
    // clock and reset
    input  wire                     core_clk_i,
    input  wire                     rst_b_i,
    // register port
    input  wire [`PIOXB_ADDR_W-1:0] reg_addr_i,
    input  wire [7:0]               reg_wdata_i,
    input  wire                     reg_wr_i,
    input  wire                     reg_rd_i,
    input  wire                     reg_rmw_i,
    output reg  [7:0]               reg_rdata_o,
    // external pins
    input  wire [NPINS-1:0]         pin_i,
    output reg  [NPINS-1:0]         pin_o,
    output reg  [NPINS-1:0]         pin_oe_b_o,
    output reg  [NPINS-1:0]         pullup_en_o,
    // on-chip peripherals
    input  wire [5:0]               periph_out_i,
    input  wire                     serial0_mode0_i,
    input  wire                     serial1_mode0_i,
    output reg  [5:0]               periph_in_o,
    // interrupt requests to the cpu
    output reg                      edge6_irq_o,
    output reg                      edge7_irq_o
);

    // ==========================================================
    // register state
    reg  [NPINS-1:0] latch_reg;
    reg  [NPINS-1:0] mode_reg;
    reg  [7:0]       inmode_reg;
    reg  [7:0]       cfg3_reg;
    reg  [1:0]       edge_flag_reg;
    reg  [1:0]       edge_pol_reg;
    reg  [1:0]       irq_en_reg;
    reg  [2:0]       pen_reg;
    reg  [1:0]       edge_prev_reg;
    wire [NPINS-1:0] pin_level;

    wire crossbar_enable_bit = cfg3_reg[`PIOXB_XBAR_EN_BIT];
    wire pullup_disable_bit  = cfg3_reg[`PIOXB_PUD_BIT];

    // ==========================================================
    // pin synchroniser
    pioxb_sync #(
        .WIDTH      (NPINS)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .async_i    (pin_i),
        .level_o    (pin_level)
    );

    // port 1 (pins 8..15) analog when input mode bit is 0
    function is_analog;
        input integer p;
        input [7:0]   inm;
        begin
            is_analog = (p >= 8) && (p < 16) && !inm[p - 8];
        end
    endfunction

    // ==========================================================
    // crossbar assignment
    reg [`PIOXB_NUM_SIG-1:0] sig_en;
    reg [3*NPINS-1:0]        pin_sig;
    integer                  p;
    integer                  s;
    integer                  nxt;
    reg                      found;

    always @* begin
        sig_en = {`PIOXB_NUM_SIG{1'b0}};
        pin_sig = {NPINS{`PIOXB_SIG_NONE}};
        nxt = 0;
        found = 1'b0;
        sig_en[`PIOXB_SIG_SDA] = pen_reg[`PIOXB_PEN_SERBUS_BIT];
        sig_en[`PIOXB_SIG_SCL] = pen_reg[`PIOXB_PEN_SERBUS_BIT];
        sig_en[`PIOXB_SIG_TX0] = pen_reg[`PIOXB_PEN_SERIAL0_BIT];
        sig_en[`PIOXB_SIG_RX0] = pen_reg[`PIOXB_PEN_SERIAL0_BIT];
        sig_en[`PIOXB_SIG_TX1] = pen_reg[`PIOXB_PEN_SERIAL1_BIT];
        sig_en[`PIOXB_SIG_RX1] = pen_reg[`PIOXB_PEN_SERIAL1_BIT];
        // walk pins low to high, handing out the next enabled signal
        for (p = 0; p < NPINS; p = p + 1) begin
            if (!is_analog(p, inmode_reg)) begin
                found = 1'b0;
                for (s = 0; s < `PIOXB_NUM_SIG; s = s + 1) begin
                    if (!found && s >= nxt && sig_en[s]) begin
                        found = 1'b1;
                        pin_sig[3*p +: 3] = s[2:0];
                        nxt = s + 1;
                    end
                end
                if (!found) begin
                    nxt = `PIOXB_NUM_SIG;
                end
            end
        end
    end

    // ==========================================================
    // pin drivers and pull-ups
    reg [2:0] sig;
    reg       allocated;
    reg       out_val;
    reg       can_drive;
    reg       force_od;
    reg       drv_low;
    reg       drv_high;
    integer   q;

    always @* begin
        sig = `PIOXB_SIG_NONE;
        allocated = 1'b0;
        out_val = 1'b1;
        can_drive = 1'b0;
        force_od = 1'b0;
        drv_low = 1'b0;
        drv_high = 1'b0;
        pin_o = {NPINS{1'b1}};
        pin_oe_b_o = {NPINS{1'b1}};
        pullup_en_o = {NPINS{1'b0}};
        periph_in_o = {6{1'b1}};
        for (q = 0; q < NPINS; q = q + 1) begin
            sig = pin_sig[3*q +: 3];
            allocated = (sig != `PIOXB_SIG_NONE);
            out_val = allocated ? periph_out_i[sig] : latch_reg[q];
            can_drive = 1'b1;
            force_od = 1'b0;
            case (sig)
                `PIOXB_SIG_SDA, `PIOXB_SIG_SCL: begin
                    force_od = 1'b1;
                end
                `PIOXB_SIG_RX0: begin
                    can_drive = serial0_mode0_i;
                    force_od = 1'b1;
                end
                `PIOXB_SIG_RX1: begin
                    can_drive = serial1_mode0_i;
                    force_od = 1'b1;
                end
                default: begin
                    can_drive = 1'b1;
                end
            endcase
            // open-drain releases on 1, push-pull drives both levels
            drv_low = crossbar_enable_bit && can_drive && !out_val;
            drv_high = crossbar_enable_bit && can_drive && out_val
                       && mode_reg[q] && !force_od;
            pin_o[q] = out_val;
            pin_oe_b_o[q] = !(drv_low || drv_high);
            // no pull-up fighting its own low driver
            pullup_en_o[q] = !pullup_disable_bit && !drv_low
                             && !is_analog(q, inmode_reg);
            if (allocated) begin
                periph_in_o[sig] = pin_level[q];
            end
        end
    end

    // digital input path, analog port 1 pins read as 0
    reg [NPINS-1:0] pin_read;
    integer         r;

    always @* begin
        pin_read = pin_level;
        for (r = 0; r < NPINS; r = r + 1) begin
            if (is_analog(r, inmode_reg)) begin
                pin_read[r] = 1'b0;
            end
        end
    end

    // ==========================================================
    // edge detection on port 3 pins 6 and 7
    wire [1:0] edge_now = {pin_level[`PIOXB_EDGE7_PIN], pin_level[`PIOXB_EDGE6_PIN]};
    wire [1:0] rise = edge_now & ~edge_prev_reg;
    wire [1:0] fall = ~edge_now & edge_prev_reg;
    wire [1:0] edge_hit = (edge_pol_reg & rise) | (~edge_pol_reg & fall);

    // ==========================================================
    // register writes
    wire       bit_acc = reg_addr_i[5] == `PIOXB_BIT_WIN;
    wire [4:0] bit_idx = reg_addr_i[4:0];
    wire [1:0] byte_port = reg_addr_i[1:0];
    integer    b;

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            latch_reg     <= {4{`PIOXB_LATCH_RST}};
            mode_reg      <= {4{`PIOXB_MODE_RST}};
            inmode_reg    <= `PIOXB_INMODE_RST;
            cfg3_reg      <= `PIOXB_CFG3_RST;
            edge_flag_reg <= 2'b00;
            edge_pol_reg  <= 2'b00;
            irq_en_reg    <= 2'b00;
            pen_reg       <= 3'b000;
            edge_prev_reg <= 2'b11;
        end else begin
            edge_prev_reg <= edge_now;
            if (reg_wr_i && bit_acc) begin
                latch_reg[bit_idx] <= reg_wdata_i[0];
            end else if (reg_wr_i) begin
                case (reg_addr_i)
                    `PIOXB_PORT0_LATCH, `PIOXB_PORT1_LATCH,
                    `PIOXB_PORT2_LATCH, `PIOXB_PORT3_LATCH: begin
                        latch_reg[8*byte_port +: 8] <= reg_wdata_i;
                    end
                    `PIOXB_PORT0_MODE, `PIOXB_PORT1_MODE,
                    `PIOXB_PORT2_MODE, `PIOXB_PORT3_MODE: begin
                        mode_reg[8*byte_port +: 8] <= reg_wdata_i;
                    end
                    `PIOXB_PORT1_INMODE: begin
                        inmode_reg <= reg_wdata_i;
                    end
                    `PIOXB_XBAR_CFG3: begin
                        cfg3_reg <= reg_wdata_i;
                    end
                    `PIOXB_EDGE_FLAGS: begin
                        edge_pol_reg <= reg_wdata_i[`PIOXB_EDGE7_POL_BIT:`PIOXB_EDGE6_POL_BIT];
                    end
                    `PIOXB_EDGE_IRQ_EN: begin
                        irq_en_reg <= reg_wdata_i[1:0];
                    end
                    `PIOXB_PERIPH_EN: begin
                        pen_reg <= reg_wdata_i[2:0];
                    end
                    default: begin
                        pen_reg <= pen_reg;
                    end
                endcase
            end
            // flags: writing 0 clears, a same-cycle edge wins
            for (b = 0; b < 2; b = b + 1) begin
                if (edge_hit[b]) begin
                    edge_flag_reg[b] <= 1'b1;
                end else if (reg_wr_i && !bit_acc && reg_addr_i == `PIOXB_EDGE_FLAGS
                             && !reg_wdata_i[b]) begin
                    edge_flag_reg[b] <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // interrupt requests
    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            edge6_irq_o <= 1'b0;
            edge7_irq_o <= 1'b0;
        end else begin
            edge6_irq_o <= edge_flag_reg[`PIOXB_EDGE6_FLAG_BIT] && irq_en_reg[0];
            edge7_irq_o <= edge_flag_reg[`PIOXB_EDGE7_FLAG_BIT] && irq_en_reg[1];
        end
    end

    // ==========================================================
    // register reads, data valid the cycle after the strobe
    reg [NPINS-1:0] rd_src;
    reg [7:0]       rd_next;

    // rmw sees the latch, so a bit set cannot copy a pin held low
    // by the board back into the latch
    always @* begin
        rd_src = reg_rmw_i ? latch_reg : pin_read;
        rd_next = 8'h00;
        if (bit_acc) begin
            rd_next = {7'h00, rd_src[bit_idx]};
        end else begin
            case (reg_addr_i)
                `PIOXB_PORT0_LATCH, `PIOXB_PORT1_LATCH,
                `PIOXB_PORT2_LATCH, `PIOXB_PORT3_LATCH: begin
                    rd_next = rd_src[8*byte_port +: 8];
                end
                `PIOXB_PORT0_MODE, `PIOXB_PORT1_MODE,
                `PIOXB_PORT2_MODE, `PIOXB_PORT3_MODE: begin
                    rd_next = mode_reg[8*byte_port +: 8];
                end
                `PIOXB_PORT1_INMODE: begin
                    rd_next = inmode_reg;
                end
                `PIOXB_XBAR_CFG3: begin
                    rd_next = cfg3_reg;
                end
                `PIOXB_EDGE_FLAGS: begin
                    rd_next = {4'h0, edge_pol_reg, edge_flag_reg};
                end
                `PIOXB_EDGE_IRQ_EN: begin
                    rd_next = {6'h00, irq_en_reg};
                end
                `PIOXB_PERIPH_EN: begin
                    rd_next = {5'h00, pen_reg};
                end
                default: begin
                    rd_next = 8'h00;
                end
            endcase
        end
    end

    always @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_next;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule

`default_nettype wire

/* verification/pioxb_asserts.sv */
// concurrent checks on the port crossbar pin block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "pioxb_regs.vh"

module pioxb_asserts #(
    parameter NPINS = 32
) (
    // clock and reset
    input wire logic                     core_clk_i,
    input wire logic                     rst_b_i,
    // register port
    input wire logic [`PIOXB_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0]               reg_wdata_i,
    input wire logic                     reg_wr_i,
    input wire logic                     reg_rd_i,
    input wire logic                     reg_rmw_i,
    input wire logic [7:0]               reg_rdata_o,
    // pins
    input wire logic [NPINS-1:0]         pin_i,
    input wire logic [NPINS-1:0]         pin_o,
    input wire logic [NPINS-1:0]         pin_oe_b_o,
    input wire logic [NPINS-1:0]         pullup_en_o,
    // peripherals and interrupts
    input wire logic [5:0]               periph_out_i,
    input wire logic                     serial0_mode0_i,
    input wire logic                     serial1_mode0_i,
    input wire logic [5:0]               periph_in_o,
    input wire logic                     edge6_irq_o,
    input wire logic                     edge7_irq_o
);
    // ==========================================================
    // shadow copies of the few registers the checks need
    logic [7:0] cfg_reg;
    logic [1:0] ien_reg;
    logic [7:0] inm_reg;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_reg <= `PIOXB_CFG3_RST;
            ien_reg <= 2'h0;
            inm_reg <= `PIOXB_INMODE_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `PIOXB_XBAR_CFG3) cfg_reg <= reg_wdata_i;
            if (reg_addr_i == `PIOXB_EDGE_IRQ_EN) ien_reg <= reg_wdata_i[1:0];
            if (reg_addr_i == `PIOXB_PORT1_INMODE) inm_reg <= reg_wdata_i;
        end
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    // ==========================================================
    // properties
    sequence s_latch_wr;
        reg_wr_i && reg_addr_i < `PIOXB_PORT0_MODE;
    endsequence
    // a gap cycle without a write keeps the latch contents known
    sequence s_rmw_same;
        reg_rd_i && reg_rmw_i && !$past(reg_wr_i) && reg_addr_i == $past(reg_addr_i, 2);
    endsequence
    property p_rd_idle;
        !reg_rd_i |=> reg_rdata_o == 8'h00;
    endproperty
    property p_unmapped;
        reg_rd_i && reg_addr_i inside {[6'h0D:6'h1F]} |=> reg_rdata_o == 8'h00;
    endproperty
    property p_rmw;
        s_latch_wr ##2 s_rmw_same |=> reg_rdata_o == $past(reg_wdata_i, 3);
    endproperty
    property p_xbar_off;
        !cfg_reg[`PIOXB_XBAR_EN_BIT] |-> &pin_oe_b_o;
    endproperty
    property p_pud;
        cfg_reg[`PIOXB_PUD_BIT] |-> pullup_en_o == '0;
    endproperty
    property p_low_no_pull;
        (~pin_oe_b_o & ~pin_o & pullup_en_o) == '0;
    endproperty
    property p_analog_read;
        reg_rd_i && !reg_rmw_i && reg_addr_i == `PIOXB_PORT1_LATCH
            |=> (reg_rdata_o & ~$past(inm_reg)) == 8'h00;
    endproperty
    property p_analog_pull;
        (pullup_en_o[15:8] & ~inm_reg) == 8'h00;
    endproperty
    property p_irq6;
        edge6_irq_o |-> $past(ien_reg[0]);
    endproperty
    property p_irq7;
        $rose(edge7_irq_o) |-> $past(ien_reg[1]);
    endproperty

    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_rmw: assert property (p_rmw) else $error("rmw read not latch");
    a_xbar_off: assert property (p_xbar_off) else $error("driver on while crossbar off");
    a_pud: assert property (p_pud) else $error("pull-up on while disabled");
    a_low_no_pull: assert property (p_low_no_pull) else $error("pull-up on low pin");
    a_analog_read: assert property (p_analog_read) else $error("analog bit read one");
    a_analog_pull: assert property (p_analog_pull) else $error("analog pin pull-up");
    a_irq6: assert property (p_irq6) else $error("edge6 request while masked");
    a_irq7: assert property (p_irq7) else $error("edge7 request while masked");
endmodule

bind pioxb_top pioxb_asserts #(.NPINS(NPINS)) u_chk (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rmw_i(reg_rmw_i), .reg_rdata_o(reg_rdata_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_b_o(pin_oe_b_o), .pullup_en_o(pullup_en_o), .periph_out_i(periph_out_i),
    .serial0_mode0_i(serial0_mode0_i), .serial1_mode0_i(serial1_mode0_i),
    .periph_in_o(periph_in_o), .edge6_irq_o(edge6_irq_o), .edge7_irq_o(edge7_irq_o));
`default_nettype wire

/* verification/pioxb_board.sv */
// board-side model: resolves each pin from device drive, board drive and pull-up
`timescale 1ns/1ps
`default_nettype none

module pioxb_board #(
    parameter NPINS = 32
) (
    // clock
    input  wire logic             core_clk_i,
    // device side
    input  wire logic [NPINS-1:0] pin_o,
    input  wire logic [NPINS-1:0] pin_oe_b_o,
    input  wire logic [NPINS-1:0] pullup_en_o,
    // board drivers
    input  wire logic [NPINS-1:0] ext_val_i,
    input  wire logic [NPINS-1:0] ext_en_i,
    // resolved level
    output logic      [NPINS-1:0] pin_lvl_o
);
    // a floating pin wanders so a stale value never reads as a match
    logic flip_reg = 1'b0;
    always @(posedge core_clk_i) flip_reg <= ~flip_reg;
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            pin_lvl_o[i] = !pin_oe_b_o[i] ? pin_o[i] :
                           ext_en_i[i] ? ext_val_i[i] :
                           pullup_en_o[i] ? 1'b1 : flip_reg ^ i[0];
        end
    end
endmodule
`default_nettype wire

/* verification/tb_port_io_crossbar_pins.sv */
// self-checking bench for the port crossbar pin block
`timescale 1ns/1ps
`default_nettype none
`include "pioxb_regs.vh"

module tb_port_io_crossbar_pins;
    logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, rmw = 1'b0;
    logic        s0m = 1'b0, s1m = 1'b0, irq6, irq7;
    logic [5:0]  addr = 6'h00, pout = 6'h00, pin_s;
    logic [7:0]  wdata = 8'h00, rdata, d, lat, mdv, ex;
    logic [31:0] lvl, po, oe_b, pu, ext_val = '0, ext_en = '0, seed = 32'hB310B179;
    int          error_cnt = 0, check_count = 0, n;

    pioxb_top #(.NPINS(32)) dut (
        .core_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rmw_i(rmw), .reg_rdata_o(rdata),
        .pin_i(lvl), .pin_o(po), .pin_oe_b_o(oe_b), .pullup_en_o(pu),
        .periph_out_i(pout), .serial0_mode0_i(s0m), .serial1_mode0_i(s1m),
        .periph_in_o(pin_s), .edge6_irq_o(irq6), .edge7_irq_o(irq7));
    pioxb_board #(.NPINS(32)) board (
        .core_clk_i(clk), .pin_o(po), .pin_oe_b_o(oe_b), .pullup_en_o(pu),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_lvl_o(lvl));
    wire [1:0]   irqs = {irq7, irq6};

    initial begin
        forever #2 clk = ~clk;
    end

    // ==========================================================
    // helpers
    function logic [31:0] xs;
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // unallocated pin with crossbar on: released only for latch 1 in open-drain
    function logic [7:0] exp_oe_b(input logic [7:0] l, input logic [7:0] m);
        return l & ~m;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [5:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [5:0] a, input logic m, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        rmw <= m;
        @(posedge clk);
        rd <= 1'b0;
        rmw <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst_b <= 1'b0;
        wt(4);
        rst_b <= 1'b1;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        do_reset();
        chk(oe_b, '1);
        chk(pu, '1);
        rreg(`PIOXB_PORT2_MODE, 1'b0, d); chk(d, 8'h00);
        rreg(`PIOXB_PORT1_INMODE, 1'b0, d); chk(d, 8'hFF);
        rreg(`PIOXB_PORT3_LATCH, 1'b1, d); chk(d, 8'hFF);
        wreg(6'h0D, 8'h5A);
        rreg(6'h0D, 1'b0, d); chk(d, 8'h00);
        for (int k = 0; k < 6; k++) begin
            for (int p = 0; p < 4; p++) begin
                wreg(`PIOXB_XBAR_CFG3, 8'h00);
                lat = xs();
                mdv = xs();
                wreg(6'(p), lat);
                wreg(6'(p + 4), mdv);
                chk(oe_b[p*8+:8], 8'hFF);
                wreg(`PIOXB_XBAR_CFG3, 8'h40);
                wt(6);
                ex = exp_oe_b(lat, mdv);
                chk(oe_b[p*8+:8], ex);
                chk(po[p*8+:8] & ~ex, lat & ~ex);
                rreg(6'(p), 1'b0, d); chk(d, lat);
                n = xs() & 7;
                wreg({1'b1, 2'(p), 3'(n)}, {7'h00, ~lat[n]});
                lat[n] = ~lat[n];
                rreg(6'(p), 1'b1, d); chk(d, lat);
            end
        end
        // peripherals on P0.0..P0.3: bus data, bus clock, tx0, rx0
        wreg(`PIOXB_PORT0_LATCH, 8'h00);
        rreg(`PIOXB_PORT0_LATCH, 1'b1, d); chk(d, 8'h00);
        wreg(`PIOXB_PORT0_MODE, 8'hFF);
        pout <= 6'b001101;
        ext_en[3] <= 1'b1;
        ext_val[3] <= seed[9];
        wreg(`PIOXB_PERIPH_EN, 8'h03);
        wt(6);
        chk(oe_b[7:0], 8'h09);
        chk(po[2:1], 2'b10);
        chk(pin_s, {2'b11, seed[9], 3'b101});
        rreg(`PIOXB_PORT0_LATCH, 1'b0, d); chk(d, {4'h0, seed[9], 3'b101});
        ext_en[3] <= 1'b0;
        s0m <= 1'b1;
        pout[3] <= 1'b1;
        wt(2);
        chk(oe_b[3], 1'b1);
        wreg(`PIOXB_PERIPH_EN, 8'h07);
        wt(1);
        chk(oe_b[5:4], 2'b10);
        s1m <= 1'b1;
        wt(1);
        chk(oe_b[5:4], 2'b00);
        wreg(`PIOXB_XBAR_CFG3, 8'hC0);
        wt(1);
        chk(pu, '0);
        wreg(`PIOXB_XBAR_CFG3, 8'h40);
        wreg(`PIOXB_PORT1_LATCH, 8'hFF);
        wreg(`PIOXB_PORT1_MODE, 8'h00);
        ext_en[15:8] <= 8'hFF;
        ext_val[15:8] <= 8'hFF;
        wreg(`PIOXB_PORT1_INMODE, 8'h0F);
        wt(6);
        rreg(`PIOXB_PORT1_LATCH, 1'b0, d); chk(d, 8'h0F);
        chk(pu[15:8], 8'h0F);
        // edge interrupts after a mid-run reset; pins released by default
        do_reset();
        wreg(`PIOXB_EDGE_IRQ_EN, 8'h03);
        for (int e = 0; e < 2; e++) begin
            for (int pol = 0; pol < 2; pol++) begin
                wreg(`PIOXB_EDGE_FLAGS, 8'(pol << (2 + e)));
                ext_en[30+e] <= 1'b1;
                ext_val[30+e] <= ~pol[0];
                wt(6);
                ext_val[30+e] <= pol[0];
                for (n = 0; n < 12 && irqs[e] !== 1'b1; n++) wt(1);
                if (n == 12) begin
                    error_cnt++;
                    $display("[ERR] %0t edge request never came", $time);
                    conclude();
                end
                chk(irqs[e], 1'b1);
                rreg(`PIOXB_EDGE_FLAGS, 1'b0, d); chk(d[e], 1'b1);
                wreg(`PIOXB_EDGE_FLAGS, 8'(pol << (2 + e)));
                ext_val[30+e] <= ~pol[0];
                wt(8);
                chk(irqs[e], 1'b0);
            end
        end
        conclude();
    end
endmodule
`default_nettype wire
